// File: logic/fid_map.svh
`ifndef FID_MAP_SVH
`define FID_MAP_SVH

// Opcodes
`define FID_OPC_ID_PAIR 8'h90
`define FID_OPC_LATCH_SET 8'h06
`define FID_OPC_LATCH_CLR 8'h04
`define FID_OPC_STATUS 8'h05
`define FID_OPC_PAR_ENTER 8'h55
`define FID_OPC_PAR_EXIT 8'h45

// Status byte field positions
`define FID_ST_BUSY 0
`define FID_ST_LATCH 1
`define FID_ST_BP_LO 2
`define FID_ST_BP3 5
`define FID_ST_LOCK 7

// Link bit counter: opcode ends at 7, address at 31, data wraps 63 -> 32
`define FID_CNT_W 6
`define FID_CNT_ZERO 6'h00
`define FID_CNT_ONE 6'h01
`define FID_CNT_OPC_LAST 6'h07
`define FID_CNT_ADDR_LAST 6'h1F
`define FID_CNT_WRAP 6'h3F
`define FID_CNT_RELOAD 6'h20

// Reset values
`define FID_LATCH_RST 1'b0
`define FID_PMODE_RST 1'b0
`define FID_OPC_RST 8'h00

`endif

// File: logic/fid_pkg.sv
package fid_pkg;

  // Link phase within one selected frame
  typedef enum logic [2:0] {
    FID_PH_OPCODE = 3'b000,
    FID_PH_ADDR = 3'b001,
    FID_PH_ID = 3'b010,
    FID_PH_STATUS = 3'b011,
    FID_PH_IDLE = 3'b100
  } fid_phase_t;

  typedef logic [7:0] fid_byte_t;

endpackage : fid_pkg

// File: logic/fid_cross_if.sv
`timescale 1ns/1ps
// Signals entering the reference clock domain and their synchronised copies
interface fid_cross_if;
  logic cs_n_raw;
  logic wp_n_raw;
  logic tog_raw;
  logic cs_n_s;
  logic wp_n_s;
  logic tog_s;

  modport sync (input cs_n_raw, input wp_n_raw, input tog_raw,
                output cs_n_s, output wp_n_s, output tog_s);
  modport core (output cs_n_raw, output wp_n_raw, output tog_raw,
                input cs_n_s, input wp_n_s, input tog_s);
endinterface : fid_cross_if

// File: logic/fid_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser bank; first stage feeds only the second
module fid_sync
  import fid_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  fid_cross_if.sync xif
);

  logic [2:0] meta_q;
  logic [2:0] stab_q;

  // Reset to the idle levels: deselected, pin high, toggle clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 3'h3;
      stab_q <= 3'h3;
    end
    else
    begin
      meta_q <= {xif.tog_raw, xif.wp_n_raw, xif.cs_n_raw};
      stab_q <= meta_q;
    end
  end

  assign xif.cs_n_s = stab_q[0];
  assign xif.wp_n_s = stab_q[1];
  assign xif.tog_s = stab_q[2];

endmodule : fid_sync

// File: logic/fid_flash_cmd.sv
`timescale 1ns/1ps
`include "fid_map.svh"
// Identification, write latch and status commands of the serial flash
module fid_flash_cmd
  import fid_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'hA5, // Arbitrary value
  parameter logic [7:0] CAP_ID = 8'h3C, // Arbitrary value
  parameter bit SMALL_SECTOR = 1'b0
)
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  output logic [7:0] PARALLEL_OUT_BUS,
  output logic PARALLEL_OUT_BUS_OE,
  input wire logic PROTECT_PIN_N,
  input wire logic BUSY_FLAG,
  input wire logic OP_DONE,
  input wire logic STATUS_LOCK_FLAG,
  input wire logic [3:0] PROTECT_CODE,
  output logic WRITE_LATCH,
  output logic PARALLEL_MODE,
  output logic HW_PROTECT,
  output logic STANDBY
);

  // Compare a received opcode against a code
  function automatic logic cmd_hit(input fid_byte_t opc, input fid_byte_t code);
    cmd_hit = (opc == code);
  endfunction : cmd_hit

  // ---- Reference clock domain declarations
  fid_cross_if xif ();
  logic link_rst_q;
  logic cs_prev_q;
  logic seen_q;
  logic latch_q;
  logic latch_d;
  logic pmode_q;
  logic pmode_d;
  logic hwp_q;
  logic standby_q;
  fid_byte_t status_hold_q;
  fid_byte_t status_now;
  logic cs_rise;
  logic cmd_new;
  logic do_set;
  logic do_clr;
  logic do_enter;
  logic do_exit;

  // ---- Link domain declarations
  logic [`FID_CNT_W-1:0] cnt_q;
  logic [`FID_CNT_W-1:0] cnt_nx;
  logic [6:0] sh_q;
  fid_byte_t opc_in;
  fid_byte_t opc_q;
  logic tog_q;
  logic algn_q;
  logic addr0_q;
  fid_phase_t phase_q;
  fid_phase_t phase_nx;
  logic opc_last;
  logic addr_last;
  logic rd_active;
  logic id_sel;
  logic [2:0] bit_idx;
  fid_byte_t out_byte;
  logic so_q;
  logic so_oe_q;
  fid_byte_t po_q;
  logic po_oe_q;

  // Pins and the opcode toggle cross through the synchroniser bank
  // Only the toggle crosses for a command; the opcode it stands for is read
  // once the toggle has passed both stages.
  assign xif.cs_n_raw = CS_N;
  assign xif.wp_n_raw = PROTECT_PIN_N;
  assign xif.tog_raw = tog_q;

  fid_sync u_sync (
    .clk(REF_CLK),
    .rst(SRST),
    .xif(xif.sync)
  );

  // ================= Reference clock domain =================

  // Link reset is a registered copy, never the raw port
  // Registering keeps reset glitches off the link's asynchronous clears
  always_ff @(posedge REF_CLK)
  begin
    link_rst_q <= SRST;
  end

  // A frame ends on the synchronised rising edge of select
  assign cs_rise = xif.cs_n_s & ~cs_prev_q;
  // Opcode, alignment and toggle are quiet once select is high
  // Opcode and alignment are written by the shift clock long before select
  // rises, so they have settled by the time the toggle arrives here.
  // Limitation: clocks after select rises would move the alignment flag.
  assign cmd_new = cs_rise & (xif.tog_s != seen_q) & algn_q;
  assign do_set = cmd_new & cmd_hit(opc_q, `FID_OPC_LATCH_SET);
  assign do_clr = cmd_new & cmd_hit(opc_q, `FID_OPC_LATCH_CLR);
  assign do_enter = cmd_new & cmd_hit(opc_q, `FID_OPC_PAR_ENTER);
  assign do_exit = cmd_new & cmd_hit(opc_q, `FID_OPC_PAR_EXIT);

  // Set wins over a completion clear arriving in the same cycle
  // Latch commands land even while busy; refusing them is the operation's job
  assign latch_d = do_set ? 1'b1 :
                   (do_clr | OP_DONE) ? 1'b0 : latch_q;
  assign pmode_d = do_enter ? 1'b1 : do_exit ? 1'b0 : pmode_q;

  // Status byte assembled from live state
  always_comb
  begin
    status_now = 8'h00;
    status_now[`FID_ST_BUSY] = BUSY_FLAG;
    status_now[`FID_ST_LATCH] = latch_q;
    status_now[`FID_ST_BP_LO +: 3] = PROTECT_CODE[2:0];
    status_now[`FID_ST_BP3] = SMALL_SECTOR ? PROTECT_CODE[3] : 1'b0;
    status_now[`FID_ST_LOCK] = STATUS_LOCK_FLAG;
  end

  // Frame bookkeeping and command state
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      cs_prev_q <= 1'b1;
      seen_q <= 1'b0;
      latch_q <= `FID_LATCH_RST;
      pmode_q <= `FID_PMODE_RST;
    end
    else
    begin
      cs_prev_q <= xif.cs_n_s;
      if (cs_rise)
      begin
        seen_q <= xif.tog_s;
      end
      latch_q <= latch_d;
      pmode_q <= pmode_d;
    end
  end

  // Status snapshot only while deselected, so the link reads a still word
  // The link reads it without a synchroniser: it freezes a few core clocks
  // after select falls, and the first status bit leaves eight shift clocks
  // into the frame, far later.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      status_hold_q <= 8'h00;
      hwp_q <= 1'b0;
      standby_q <= 1'b1;
    end
    else
    begin
      if (xif.cs_n_s)
      begin
        status_hold_q <= status_now;
      end
      hwp_q <= STATUS_LOCK_FLAG & ~xif.wp_n_s;
      standby_q <= xif.cs_n_s;
    end
  end

  assign WRITE_LATCH = latch_q;
  assign PARALLEL_MODE = pmode_q;
  assign HW_PROTECT = hwp_q;
  assign STANDBY = standby_q;

  // ================= Link (shift clock) domain =================

  // Data phase counts 32..63 and wraps to 32, keeping byte alignment
  // Reloading 32 or 0 makes no difference; phase_q alone keeps the frame out of the opcode and address phases
  assign cnt_nx = (cnt_q == `FID_CNT_WRAP) ? `FID_CNT_RELOAD : cnt_q + `FID_CNT_ONE;
  assign opc_in = {sh_q, SI};
  assign opc_last = (phase_q == FID_PH_OPCODE) && (cnt_q == `FID_CNT_OPC_LAST);
  assign addr_last = (phase_q == FID_PH_ADDR) && (cnt_q == `FID_CNT_ADDR_LAST);

  // Phase decode at the opcode and address boundaries
  // Unknown opcodes park in idle, so further clocks shift nothing out
  always_comb
  begin
    phase_nx = phase_q;
    unique case (phase_q)
      FID_PH_OPCODE:
      begin
        if (opc_last)
        begin
          if (cmd_hit(opc_in, `FID_OPC_ID_PAIR))
          begin
            phase_nx = FID_PH_ADDR;
          end
          else if (cmd_hit(opc_in, `FID_OPC_STATUS))
          begin
            phase_nx = FID_PH_STATUS;
          end
          else
          begin
            phase_nx = FID_PH_IDLE;
          end
        end
      end
      FID_PH_ADDR:
      begin
        if (addr_last)
        begin
          phase_nx = FID_PH_ID;
        end
      end
      FID_PH_ID: phase_nx = FID_PH_ID;
      FID_PH_STATUS: phase_nx = FID_PH_STATUS;
      FID_PH_IDLE: phase_nx = FID_PH_IDLE;
      default: phase_nx = FID_PH_IDLE;
    endcase
  end

  // Frame state clears while select is high
  // Asynchronous on select, so a frame cut short ends without another clock
  always_ff @(posedge SCK or posedge CS_N)
  begin
    if (CS_N)
    begin
      cnt_q <= `FID_CNT_ZERO;
      sh_q <= 7'h00;
      phase_q <= FID_PH_OPCODE;
      addr0_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_nx;
      sh_q <= opc_in[6:0];
      phase_q <= phase_nx;
      if (addr_last)
      begin
        addr0_q <= SI;
      end
    end
  end

  // Results that outlive the frame for the other domain to read
  always_ff @(posedge SCK or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      opc_q <= `FID_OPC_RST;
      tog_q <= 1'b0;
      algn_q <= 1'b0;
    end
    else
    begin
      algn_q <= (cnt_nx[2:0] == 3'h0);
      if (opc_last)
      begin
        opc_q <= opc_in;
        tog_q <= ~tog_q;
      end
    end
  end

  // Byte selection; parallel steps a byte per clock, serial per eight
  // Parallel mode is read raw here; it moves only a few core clocks after
  // select rises, while select still holds these outputs cleared.
  // Counter bit 3 flips every eighth clock, bit 0 every clock.
  assign rd_active = (phase_q == FID_PH_ID) || (phase_q == FID_PH_STATUS);
  assign id_sel = addr0_q ^ (pmode_q ? cnt_q[0] : cnt_q[3]);
  assign out_byte = (phase_q == FID_PH_STATUS) ? status_hold_q :
                    (id_sel ? CAP_ID : MFR_ID);
  assign bit_idx = ~cnt_q[2:0]; // MSB first

  // Outputs change on the falling shift clock edge
  // Half a clock of setup for the host, which samples on the rising edge
  always_ff @(negedge SCK or posedge CS_N)
  begin
    if (CS_N)
    begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      po_q <= 8'h00;
      po_oe_q <= 1'b0;
    end
    else
    begin
      so_q <= out_byte[bit_idx];
      so_oe_q <= rd_active & ~pmode_q;
      po_q <= out_byte;
      po_oe_q <= rd_active & pmode_q;
    end
  end

  assign SO = so_q;
  assign SO_OE = so_oe_q;
  assign PARALLEL_OUT_BUS = po_q;
  assign PARALLEL_OUT_BUS_OE = po_oe_q;

endmodule : fid_flash_cmd

// File: tb/fid_flash_cmd_props.sv
`timescale 1ns/1ps
// Checks on the top ports, all seen from the core clock
module fid_flash_cmd_props (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SO,
  input wire logic SO_OE,
  input wire logic [7:0] PARALLEL_OUT_BUS,
  input wire logic PARALLEL_OUT_BUS_OE,
  input wire logic PROTECT_PIN_N,
  input wire logic OP_DONE,
  input wire logic STATUS_LOCK_FLAG,
  input wire logic WRITE_LATCH,
  input wire logic PARALLEL_MODE,
  input wire logic HW_PROTECT,
  input wire logic STANDBY
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);
  // Deep in a frame, clear of the last command's settling time
  sequence s_in_frame;
    (!CS_N)[*6];
  endsequence
  a_oe_release: assert property (CS_N |-> !SO_OE && !PARALLEL_OUT_BUS_OE)
    else $error("Output enabled outside frame");
  a_standby_on: assert property (CS_N[*4] |=> STANDBY)
    else $error("No standby");
  a_latch_hold: assert property (s_in_frame ##0 !OP_DONE |=> $stable(WRITE_LATCH))
    else $error("Latch moved in frame");
  a_done_clear: assert property (OP_DONE && CS_N && $past(CS_N, 8) |=> !WRITE_LATCH)
    else $error("Latch kept after done");
  a_mode_hold: assert property (s_in_frame |=> $stable(PARALLEL_MODE))
    else $error("Mode moved in frame");
  a_par_oe: assert property (PARALLEL_OUT_BUS_OE |-> PARALLEL_MODE)
    else $error("Bus driven in serial mode");
  a_out_steady: assert property (SCK && $past(SCK) && !CS_N && !$past(CS_N) |->
    $stable(SO) && $stable(PARALLEL_OUT_BUS)) else $error("Output moved while clock high");
  a_hw_on: assert property ((STATUS_LOCK_FLAG && !PROTECT_PIN_N)[*4] |=> HW_PROTECT)
    else $error("No hardware protect");
  a_reset_clear: assert property ($fell(SRST) |-> !WRITE_LATCH && !PARALLEL_MODE)
    else $error("Latch or mode set after reset");
  a_standby_off: assert property ((!CS_N)[*4] |=> !STANDBY)
    else $error("Standby kept in frame");
  a_ser_oe: assert property (SO_OE |-> !PARALLEL_MODE)
    else $error("Serial line driven in parallel mode");
  a_hw_off: assert property (!STATUS_LOCK_FLAG |=> !HW_PROTECT)
    else $error("Protect without lock flag");
endmodule : fid_flash_cmd_props

bind fid_flash_cmd fid_flash_cmd_props u_fid_flash_cmd_props (.REF_CLK, .SRST, .SCK, .CS_N,
  .SO, .SO_OE, .PARALLEL_OUT_BUS, .PARALLEL_OUT_BUS_OE, .PROTECT_PIN_N, .OP_DONE,
  .STATUS_LOCK_FLAG, .WRITE_LATCH, .PARALLEL_MODE, .HW_PROTECT, .STANDBY);

// File: tb/fid_host_model.sv
`timescale 1ns/1ps
// Host on the link; SCK rests low between frames
module fid_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_b,
  input wire logic [7:0] po
);
  logic [7:0] rx[$];
  logic [7:0] rx_b[$];
  logic [7:0] sh;
  logic [7:0] sh_b;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // n_tx bits out MSB first, then n_rx bytes back; SI toggles once unused
  task automatic frame(input logic [31:0] tx, input int n_tx, input int n_rx, input bit par);
    rx.delete();
    rx_b.delete();
    // Off the whole-nanosecond grid, so no link edge meets a core clock edge
    #7.3 cs_n = 1'b0;
    for (int i = 0; i < n_tx + n_rx * (par ? 1 : 8); i++)
    begin
      si = (i < n_tx) ? tx[31 - i] : ~si;
      #80 sck = 1'b1;
      sh = {sh[6:0], so};
      sh_b = {sh_b[6:0], so_b};
      if (i >= n_tx && (par || (i - n_tx) % 8 == 7))
      begin
        rx.push_back(par ? po : sh);
        rx_b.push_back(sh_b);
      end
      #80 sck = 1'b0;
    end
    #80 cs_n = 1'b1;
    // Gap covers both the idle time and the command settling
    #400;
  endtask : frame
endmodule : fid_host_model

// File: tb/fid_flash_cmd_bench.sv
`timescale 1ns/1ps
module fid_flash_cmd_bench
  import fid_pkg::*;
;
  localparam fid_byte_t MFR = 8'hA5; // Arbitrary value
  localparam fid_byte_t CAP = 8'h3C; // Arbitrary value
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic busy = 1'b1;
  logic done = 1'b0;
  logic lock = 1'b1;
  logic pin_n = 1'b1;
  logic [3:0] code = 4'hD;
  logic sck, cs_n, si, so, so_oe, po_oe, latch, pmode, hwp, stby;
  fid_byte_t po;
  fid_byte_t got[$];
  logic so_b, so_oe_b, so_line, so_b_line;
  fid_byte_t po_line;
  fid_byte_t got_b[$];
  int n_errors = 0;
  int compares = 0;

  always #25 ref_clk = ~ref_clk;

  fid_flash_cmd #(.MFR_ID(MFR), .CAP_ID(CAP), .SMALL_SECTOR(1'b0)) u_fid_flash_cmd (
    .REF_CLK(ref_clk), .SRST(srst), .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe),
    .PARALLEL_OUT_BUS(po), .PARALLEL_OUT_BUS_OE(po_oe), .PROTECT_PIN_N(pin_n),
    .BUSY_FLAG(busy), .OP_DONE(done), .STATUS_LOCK_FLAG(lock), .PROTECT_CODE(code),
    .WRITE_LATCH(latch), .PARALLEL_MODE(pmode), .HW_PROTECT(hwp), .STANDBY(stby));
  // Small-sector variant on the same link, heard on its own serial line
  fid_flash_cmd #(.MFR_ID(MFR), .CAP_ID(CAP), .SMALL_SECTOR(1'b1)) u_fid_flash_cmd_small (
    .REF_CLK(ref_clk), .SRST(srst), .SCK(sck), .CS_N(cs_n), .SI(si),
    .SO(so_b), .SO_OE(so_oe_b),
    .PARALLEL_OUT_BUS(), .PARALLEL_OUT_BUS_OE(), .PROTECT_PIN_N(pin_n),
    .BUSY_FLAG(busy), .OP_DONE(done), .STATUS_LOCK_FLAG(lock), .PROTECT_CODE(code),
    .WRITE_LATCH(), .PARALLEL_MODE(), .HW_PROTECT(), .STANDBY());

  // Pull-ups on released lines, so a missing enable reads as ones
  assign so_line = so_oe ? so : 1'b1;
  assign so_b_line = so_oe_b ? so_b : 1'b1;
  assign po_line = po_oe ? po : 8'hFF;

  fid_host_model u_fid_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line),
    .so_b(so_b_line), .po(po_line));

  // Compare and count
  task automatic chk(input fid_byte_t g, input fid_byte_t e);
    compares++;
    if (g !== e)
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    if (g !== e)
      n_errors++;
  endtask : chk

  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // One frame through the host, keeping what came back
  task automatic run(input logic [31:0] tx, input int n_tx, input int n_rx, input bit par);
    @(posedge ref_clk);
    u_fid_host_model.frame(tx, n_tx, n_rx, par);
    got = u_fid_host_model.rx;
    got_b = u_fid_host_model.rx_b;
  endtask : run

  // Expected status; code bit 3 must not show in the large-sector byte
  function automatic fid_byte_t st(input logic wl);
    return {lock, 2'b00, code[2:0], wl, busy};
  endfunction : st

  // Main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    run(32'h05000000, 8, 2, 1'b0);
    chk(got[0], st(1'b0));
    chk(got[1], st(1'b0));
    chk(got_b[0], {lock, 1'b0, code, 1'b0, busy});
    chk(got_b[1], {lock, 1'b0, code, 1'b0, busy});
    @(posedge ref_clk);
    pin_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({7'h00, hwp}, 8'h01);
    lock <= 1'b0;
    busy <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({7'h00, hwp}, 8'h00);
    run(32'h06000000, 8, 0, 1'b0);
    chk({7'h00, latch}, 8'h01);
    run(32'h05000000, 8, 1, 1'b0);
    chk(got[0], st(1'b1));
    run(32'h04000000, 8, 0, 1'b0);
    chk({7'h00, latch}, 8'h00);
    run(32'h06000000, 9, 0, 1'b0);
    chk({7'h00, latch}, 8'h00);
    run(32'h06000000, 8, 0, 1'b0);
    chk({7'h00, latch}, 8'h01);
    @(posedge ref_clk);
    done <= 1'b1;
    @(posedge ref_clk);
    done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({7'h00, latch}, 8'h00);
    // Both address orders, serial then parallel
    for (int m = 0; m < 4; m++)
    begin
      if (m == 2)
        run(32'h55000000, 8, 0, 1'b0);
      run(m[0] ? 32'h90FFFFFF : 32'h9012345E, 32, 6, m[1]);
      for (int k = 0; k < 6; k++)
        chk(got[k], ((k + m) % 2) ? CAP : MFR);
      chk({6'h00, pmode, stby}, {6'h00, m[1], 1'b1});
    end
    run(32'h05000000, 8, 3, 1'b1);
    for (int k = 0; k < 3; k++)
      chk(got[k], st(1'b0));
    run(32'h45000000, 8, 0, 1'b0);
    chk({7'h00, pmode}, 8'h00);
    // Power cycle in mid-run drops both latch and parallel mode
    run(32'h55000000, 8, 0, 1'b0);
    run(32'h06000000, 8, 0, 1'b0);
    chk({6'h00, pmode, latch}, 8'h03);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({6'h00, pmode, latch}, 8'h00);
    run(32'h06000000, 8, 0, 1'b0);
    chk({7'h00, latch}, 8'h01);
    give_verdict();
  end

  // Watchdog: the tests need well under a fifth of this
  initial
  begin
    #500000;
    n_errors++;
    give_verdict();
  end
endmodule : fid_flash_cmd_bench
